// >>> teg_top.sv
// Event flags, interrupt and DMA request gating of a 16-bit timer, APB slave
//
// Notes on behaviour
// - Trigger DMA request only while enable bit 14 is one.
// - Channel 1-4 DMA request enables at bits 9-12 gate channel requests.
// - Overflow DMA request only while enable bit 8 is one.
// - Trigger interrupt request only while enable bit 6 is one.
// - Channel 1-4 interrupt enables at bits 1-4 gate channel interrupts.
// - Overflow interrupt request only while enable bit 0 is one.
// - Channel 1 recapture flag sets on capture while its event flag is set.
// - Channels 2-4 recapture flags at bits 10-12 behave likewise.
// - Trigger flag at bit 6 sets on trigger, cleared by writing zero.
// - Trigger is the active edge, or either edge in suspend mode.
// - Input channel flag sets on capture; cleared by zero write or data read.
// - Output channel flag sets on compare; only a zero write clears it.
// - Channel 2-4 flags at bits 2-4 behave like channel 1.
// - Overflow flag at bit 0 sets on overflow, cleared by writing zero.
// - With both overflow controls zero, software request makes overflow event.
// - With both controls zero, trigger counter reinit makes overflow event.
// - In suspend mode 101 the counter counts only while trigger is high.
// - Writing one to software event bit 0 requests an overflow event.
`timescale 1ns/1ps

`include "teg_defs.svh"

module teg_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Events from the timer core
  input  wire logic        trigger_input_i,
  input  wire logic        ovf_evt_i,
  input  wire logic [3:0]  capture_i,
  input  wire logic [3:0]  compare_i,
  input  wire logic [3:0]  ch_data_rd_i,
  // Requests and counter controls
  output logic             irq_o,
  output logic             dma_ovf_o,
  output logic      [3:0]  dma_ch_o,
  output logic             dma_trg_o,
  output logic             count_en_o,
  output logic             counter_reinit_o
);

  localparam int NUM_CH = 4;

  teg_pkg::teg_reg_t  req_en_q;
  teg_pkg::teg_reg_t  status_q;
  teg_pkg::teg_reg_t  status_d;
  teg_pkg::teg_reg_t  ctrl_q;
  teg_pkg::teg_reg_t  rdata;
  teg_pkg::teg_reg_t  lane_m;
  teg_pkg::teg_reg_t  wdata;
  teg_pkg::teg_reg_t  set_v;
  teg_pkg::teg_reg_t  clr_v;
  teg_pkg::teg_smode_e smode;
  logic               pready_q;
  logic               pslverr_q;
  logic [31:0]        prdata_q;
  logic               setup;
  logic               commit;
  logic               hit_req_en;
  logic               hit_status;
  logic               hit_sw;
  logic               hit_ctrl;
  logic               hit_any;
  logic               ovf_ctrl;
  logic               ovf_src;
  logic               trg_fall;
  logic               suspend;
  logic [NUM_CH-1:0]  ch_input;
  logic [NUM_CH-1:0]  ch_set;
  logic [NUM_CH-1:0]  recap_set;
  logic [NUM_CH-1:0]  rd_clr;
  logic               trg_evt;
  logic               reinit;
  logic               sw_ovf;
  logic               ovf_gate;
  logic               ovf_set;
  logic               irq_q;
  logic               dma_ovf_q;
  logic [NUM_CH-1:0]  dma_ch_q;
  logic               dma_trg_q;
  logic               count_en_q;
  logic               reinit_q;

  // APB decode; access phase never takes a wait cycle
  assign setup      = psel_i & ~penable_i;
  assign commit     = psel_i & penable_i & pready_q & pwrite_i;
  assign hit_req_en = (paddr_i == `TEG_OFS_REQ_EN);
  assign hit_status = (paddr_i == `TEG_OFS_STATUS);
  assign hit_sw     = (paddr_i == `TEG_OFS_SW_EVENT);
  assign hit_ctrl   = (paddr_i == `TEG_OFS_CTRL);
  assign hit_any    = hit_req_en | hit_status | hit_sw | hit_ctrl;
  assign lane_m     = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign wdata      = pwdata_i[15:0];

  // Read mux, reserved bits read zero
  always_comb begin
    rdata = 16'h0000;
    case (paddr_i)
      `TEG_OFS_REQ_EN: rdata = req_en_q;
      `TEG_OFS_STATUS: rdata = status_q;
      `TEG_OFS_CTRL:   rdata = ctrl_q;
      default:         rdata = 16'h0000;
    endcase
  end

  // APB answer registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit_any;
      if (setup) begin
        prdata_q <= {16'h0000, rdata};
      end
    end
  end

  // Request enable register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_en_q <= `TEG_RST_REQ_EN;
    end else if (commit && hit_req_en) begin
      req_en_q <= ((req_en_q & ~lane_m) | (wdata & lane_m)) & `TEG_MASK_REQ_EN;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= `TEG_RST_CTRL;
    end else if (commit && hit_ctrl) begin
      ctrl_q <= ((ctrl_q & ~lane_m) | (wdata & lane_m)) & `TEG_MASK_CTRL;
    end
  end

  // Control fields
  assign ovf_ctrl = ctrl_q[`TEG_BIT_OVF_CTRL];
  assign ovf_src  = ctrl_q[`TEG_BIT_OVF_SRC];
  assign trg_fall = ctrl_q[`TEG_BIT_TRG_FALL];
  assign smode    = teg_pkg::teg_smode_e'(ctrl_q[`TEG_BIT_SMODE +: 3]);
  assign ch_input = ctrl_q[`TEG_BIT_CH1_DIR +: NUM_CH];
  assign suspend  = (smode == teg_pkg::TEG_SM_SUSPEND);

  // Trigger event detection
  teg_edge u_edge (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .level_i    (trigger_input_i),
    .falling_i  (trg_fall),
    .any_edge_i (suspend),
    .edge_o     (trg_evt)
  );

  // Overflow event sources
  assign reinit   = trg_evt & (smode == teg_pkg::TEG_SM_RESET);
  assign sw_ovf   = commit & hit_sw & lane_m[`TEG_BIT_SW_OVF] & wdata[`TEG_BIT_SW_OVF];
  assign ovf_gate = ~ovf_ctrl & ~ovf_src;
  assign ovf_set  = ovf_evt_i | (ovf_gate & (sw_ovf | reinit));

  // Per-channel set, recapture and read-clear terms
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign ch_set[i]    = ch_input[i] ? capture_i[i] : compare_i[i];
    assign recap_set[i] = ch_input[i] & capture_i[i] & status_q[`TEG_BIT_CH1_FLAG + i];
    assign rd_clr[i]    = ch_input[i] & ch_data_rd_i[i];

    chk_recap_set : assert property (@(posedge clk_i) disable iff (srst_i)
      ch_input[i] && capture_i[i] && status_q[`TEG_BIT_CH1_FLAG + i]
      |=> status_q[`TEG_BIT_CH1_RCAP + i])
      else $error("recapture flag not set");

    chk_out_rd_keep : assert property (@(posedge clk_i) disable iff (srst_i)
      !ch_input[i] && ch_data_rd_i[i] && status_q[`TEG_BIT_CH1_FLAG + i] && !commit
      |=> status_q[`TEG_BIT_CH1_FLAG + i])
      else $error("output channel flag cleared by data read");

    chk_in_rd_clear : assert property (@(posedge clk_i) disable iff (srst_i)
      ch_input[i] && ch_data_rd_i[i] && !capture_i[i]
      |=> !status_q[`TEG_BIT_CH1_FLAG + i])
      else $error("input channel flag not cleared by data read");
  end

  // Flag update; a set in the clearing cycle wins
  always_comb begin
    set_v = 16'h0000;
    set_v[`TEG_BIT_OVF_FLAG] = ovf_set;
    set_v[`TEG_BIT_TRG_FLAG] = trg_evt;
    set_v[`TEG_BIT_CH1_FLAG +: NUM_CH] = ch_set;
    set_v[`TEG_BIT_CH1_RCAP +: NUM_CH] = recap_set;
    clr_v = 16'h0000;
    if (commit && hit_status) begin
      clr_v = lane_m & ~wdata;
    end
    clr_v[`TEG_BIT_CH1_FLAG +: NUM_CH] = clr_v[`TEG_BIT_CH1_FLAG +: NUM_CH] | rd_clr;
    status_d = ((status_q & ~clr_v) | set_v) & `TEG_MASK_STATUS;
  end

  // Event status register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_q <= `TEG_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // Interrupt level from flags and their enables
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d[`TEG_BIT_TRG_FLAG:0] & req_en_q[`TEG_BIT_TRG_IRQ:0]);
    end
  end

  // DMA request pulses
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dma_ovf_q <= 1'b0;
      dma_ch_q  <= 4'h0;
      dma_trg_q <= 1'b0;
    end else begin
      dma_ovf_q <= ovf_set & req_en_q[`TEG_BIT_OVF_DMA];
      dma_ch_q  <= ch_set & req_en_q[`TEG_BIT_CH1_DMA +: NUM_CH];
      dma_trg_q <= trg_evt & req_en_q[`TEG_BIT_TRG_DMA];
    end
  end

  // Counter controls
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_en_q <= 1'b1;
      reinit_q   <= 1'b0;
    end else begin
      count_en_q <= suspend ? trigger_input_i : 1'b1;
      reinit_q   <= reinit;
    end
  end

  // Outputs
  assign prdata_o         = prdata_q;
  assign pready_o         = pready_q;
  assign pslverr_o        = pslverr_q;
  assign irq_o            = irq_q;
  assign dma_ovf_o        = dma_ovf_q;
  assign dma_ch_o         = dma_ch_q;
  assign dma_trg_o        = dma_trg_q;
  assign count_en_o       = count_en_q;
  assign counter_reinit_o = reinit_q;

  // Checks on the request gating, event flags and counter enable
  chk_trg_dma_gate : assert property (@(posedge clk_i) disable iff (srst_i)
    dma_trg_o == ($past(trg_evt) && $past(req_en_q[`TEG_BIT_TRG_DMA])))
    else $error("trigger DMA request not gated by its enable");

  chk_ch_dma_gate : assert property (@(posedge clk_i) disable iff (srst_i)
    dma_ch_o == ($past(ch_set) & $past(req_en_q[`TEG_BIT_CH1_DMA +: NUM_CH])))
    else $error("channel DMA request not gated by its enable");

  chk_ovf_dma_gate : assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(dma_ovf_o) |-> $past(req_en_q[`TEG_BIT_OVF_DMA]) && $past(ovf_set))
    else $error("overflow DMA request without enable");

  chk_irq_off : assert property (@(posedge clk_i) disable iff (srst_i)
    (req_en_q[`TEG_BIT_TRG_IRQ:0] == 7'h00) [*2] |-> !irq_o)
    else $error("interrupt while all interrupt enables are zero");

  chk_irq_level : assert property (@(posedge clk_i) disable iff (srst_i)
    $stable(req_en_q) |->
      (irq_o == |(status_q[`TEG_BIT_TRG_FLAG:0] & req_en_q[`TEG_BIT_TRG_IRQ:0])))
    else $error("interrupt level does not match flags and enables");

  chk_trg_flag : assert property (@(posedge clk_i) disable iff (srst_i)
    suspend && $changed(trigger_input_i) |=> status_q[`TEG_BIT_TRG_FLAG])
    else $error("suspend mode edge did not set trigger flag");

  chk_ovf_flag : assert property (@(posedge clk_i) disable iff (srst_i)
    ovf_evt_i |=> status_q[`TEG_BIT_OVF_FLAG])
    else $error("overflow event did not set flag");

  chk_sw_ovf : assert property (@(posedge clk_i) disable iff (srst_i)
    sw_ovf && ovf_gate |=> status_q[`TEG_BIT_OVF_FLAG])
    else $error("software overflow request lost");

  chk_sw_ovf_block : assert property (@(posedge clk_i) disable iff (srst_i)
    sw_ovf && !ovf_gate && !ovf_evt_i && !status_q[`TEG_BIT_OVF_FLAG]
    |=> !status_q[`TEG_BIT_OVF_FLAG])
    else $error("software overflow request not blocked by controls");

  chk_reinit_ovf : assert property (@(posedge clk_i) disable iff (srst_i)
    reinit && ovf_gate |=> status_q[`TEG_BIT_OVF_FLAG] && counter_reinit_o)
    else $error("trigger reinit did not raise overflow");

  chk_write_one : assert property (@(posedge clk_i) disable iff (srst_i)
    commit && hit_status && lane_m[0] && wdata[0] && status_q[`TEG_BIT_OVF_FLAG]
    |=> status_q[`TEG_BIT_OVF_FLAG])
    else $error("writing one cleared a flag");

  chk_suspend_hold : assert property (@(posedge clk_i) disable iff (srst_i)
    suspend && !trigger_input_i |=> !count_en_o)
    else $error("counter enabled in suspend mode with trigger low");

endmodule

// >>> teg_defs.svh
// Offsets, field positions and reset values of the timer event gating block
`ifndef TEG_DEFS_SVH
`define TEG_DEFS_SVH

// Register byte offsets
`define TEG_OFS_REQ_EN   12'h000
`define TEG_OFS_STATUS   12'h004
`define TEG_OFS_SW_EVENT 12'h008
`define TEG_OFS_CTRL     12'h00c

// request_enable fields
`define TEG_BIT_OVF_IRQ  0
`define TEG_BIT_CH1_IRQ  1
`define TEG_BIT_TRG_IRQ  6
`define TEG_BIT_OVF_DMA  8
`define TEG_BIT_CH1_DMA  9
`define TEG_BIT_TRG_DMA  14

// event_status fields
`define TEG_BIT_OVF_FLAG 0
`define TEG_BIT_CH1_FLAG 1
`define TEG_BIT_TRG_FLAG 6
`define TEG_BIT_CH1_RCAP 9

// software_event_reg fields
`define TEG_BIT_SW_OVF   0

// control_reg_1 fields
`define TEG_BIT_OVF_CTRL 0
`define TEG_BIT_OVF_SRC  1
`define TEG_BIT_TRG_FALL 2
`define TEG_BIT_SMODE    4
`define TEG_BIT_CH1_DIR  8

// Implemented bit masks
`define TEG_MASK_REQ_EN  16'h5f5f
`define TEG_MASK_STATUS  16'h1e5f
`define TEG_MASK_CTRL    16'h0f77

// Reset values
`define TEG_RST_REQ_EN   16'h0000
`define TEG_RST_STATUS   16'h0000
`define TEG_RST_CTRL     16'h0000

`endif

// >>> teg_pkg.sv
// Types shared by the timer event gating block
package teg_pkg;

  // One 16-bit register image
  typedef logic [15:0] teg_reg_t;

  // Subordinate mode codes
  typedef enum logic [2:0] {
    TEG_SM_OFF     = 3'h0,
    TEG_SM_ENC_A   = 3'h1,
    TEG_SM_ENC_B   = 3'h2,
    TEG_SM_ENC_C   = 3'h3,
    TEG_SM_RESET   = 3'h4,
    TEG_SM_SUSPEND = 3'h5,
    TEG_SM_TRIGGER = 3'h6,
    TEG_SM_EXTCLK  = 3'h7
  } teg_smode_e;

endpackage

// >>> teg_edge.sv
// Trigger edge detector with selectable polarity and either-edge mode
`timescale 1ns/1ps

module teg_edge (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Level and edge selection
  input  wire logic level_i,
  input  wire logic falling_i,
  input  wire logic any_edge_i,
  // One-cycle edge pulse
  output logic      edge_o
);

  logic level_q;
  logic rise;
  logic fall;

  // Previous level of the trigger; reset loads the live level so no false edge follows
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level_q <= level_i;
    end else begin
      level_q <= level_i;
    end
  end

  // Edge selection
  assign rise   = level_i & ~level_q;
  assign fall   = ~level_i & level_q;
  assign edge_o = any_edge_i ? (rise | fall) : (falling_i ? fall : rise);

endmodule

// >>> teg_far_end.sv
// Model of interrupt controller and DMA controller seen by the block
`timescale 1ns/1ps

module teg_far_end (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Requests from the block
  input  wire logic       irq_i,
  input  wire logic       dma_ovf_i,
  input  wire logic [3:0] dma_ch_i,
  input  wire logic       dma_trg_i
);
  // Served DMA requests: 0 overflow, 1-4 channels, 5 trigger
  int cnt [6];
  // Pending interrupt level as seen by the core
  logic irq_pend;

  // One transfer served for each request pulse
  always @(posedge clk_i) begin
    if (srst_i) begin
      foreach (cnt[i]) cnt[i] <= 0;
    end else begin
      cnt[0] <= cnt[0] + dma_ovf_i;
      for (int i = 0; i < 4; i++) cnt[i+1] <= cnt[i+1] + dma_ch_i[i];
      cnt[5] <= cnt[5] + dma_trg_i;
    end
  end

  // Interrupt line is a level
  assign irq_pend = irq_i;
endmodule

// >>> timer_event_irq_dma_gating_tb.sv
// Self-checking bench of the timer event gating block
`timescale 1ns/1ps

`include "teg_defs.svh"

module timer_event_irq_dma_gating_tb;
  logic        clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic [3:0]  pstrb_i = 4'h3, capture_i = '0, compare_i = '0, ch_data_rd_i = '0, dma_ch_o;
  logic        trigger_input_i = 0, ovf_evt_i = 0, pready_o, pslverr_o, irq_o, dma_ovf_o;
  logic        dma_trg_o, count_en_o, counter_reinit_o, serr;
  int          err_count = 0, n_tests = 0, snap [6];

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  teg_top dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .trigger_input_i(trigger_input_i), .ovf_evt_i(ovf_evt_i), .capture_i(capture_i),
    .compare_i(compare_i), .ch_data_rd_i(ch_data_rd_i), .irq_o(irq_o),
    .dma_ovf_o(dma_ovf_o), .dma_ch_o(dma_ch_o), .dma_trg_o(dma_trg_o),
    .count_en_o(count_en_o), .counter_reinit_o(counter_reinit_o));

  teg_far_end far (.clk_i(clk_i), .srst_i(srst_i), .irq_i(irq_o), .dma_ovf_i(dma_ovf_o),
    .dma_ch_i(dma_ch_o), .dma_trg_i(dma_trg_o));

  // Verdict and end of run
  task results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One APB transfer, entered just after a rising edge; ends after one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    serr = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    @(posedge clk_i);
  endtask

  task stat(input string nm, input logic [31:0] exp);
    apb(0, `TEG_OFS_STATUS, 0);
    chk(nm, exp, rd);
  endtask

  task dma(input int i, input int exp);
    chk("dma count", exp, far.cnt[i] - snap[i]);
  endtask

  task t_reset();
    apb(0, `TEG_OFS_REQ_EN, 0); chk("req_en rst", 0, rd);
    stat("status rst", 0);
    apb(0, `TEG_OFS_CTRL, 0); chk("ctrl rst", 0, rd);
    apb(0, 12'h010, 0); chk("unmapped err", 1, serr); chk("unmapped data", 0, rd);
    apb(1, `TEG_OFS_REQ_EN, 32'h5f5f); apb(0, `TEG_OFS_REQ_EN, 0);
    chk("req_en rw", 32'h5f5f, rd);
    pstrb_i <= 4'h1; apb(1, `TEG_OFS_REQ_EN, 0); pstrb_i <= 4'h3;
    apb(0, `TEG_OFS_REQ_EN, 0); chk("lane keep", 32'h5f00, rd);
    chk("count_en", 1, count_en_o);
  endtask

  task t_ovf();
    apb(1, `TEG_OFS_REQ_EN, 32'h0001); snap = far.cnt;
    ovf_evt_i <= 1; tick(1); ovf_evt_i <= 0; tick(3);
    chk("irq ovf", 1, far.irq_pend);
    dma(0, 0);
    apb(1, `TEG_OFS_STATUS, 32'h1e5f); stat("ovf keep", 1);
    apb(1, `TEG_OFS_STATUS, 32'h1e5e); stat("ovf clr", 0);
    tick(2); chk("irq off", 0, irq_o);
    apb(1, `TEG_OFS_REQ_EN, 32'h0100); snap = far.cnt;
    ovf_evt_i <= 1; tick(1); ovf_evt_i <= 0; tick(3);
    dma(0, 1);
    chk("irq masked", 0, irq_o);
    apb(1, `TEG_OFS_STATUS, 0);
  endtask

  task t_chan();
    apb(1, `TEG_OFS_CTRL, 32'h0f00); apb(1, `TEG_OFS_REQ_EN, 32'h1e1e); snap = far.cnt;
    capture_i <= 4'hf; tick(1); capture_i <= 0; tick(3);
    stat("ch flags", 32'h001e);
    for (int i = 1; i < 5; i++) dma(i, 1);
    chk("irq ch", 1, irq_o);
    capture_i <= 4'hf; tick(1); capture_i <= 0; tick(2);
    stat("recapture", 32'h1e1e);
    ch_data_rd_i <= 4'hf; tick(1); ch_data_rd_i <= 0; tick(2);
    stat("data read clr", 32'h1e00);
    apb(1, `TEG_OFS_STATUS, 0); stat("rcap clr", 0);
    apb(1, `TEG_OFS_REQ_EN, 0); snap = far.cnt;
    capture_i <= 4'h5; tick(1); capture_i <= 0; tick(3);
    dma(1, 0);
    dma(3, 0);
    chk("irq ch masked", 0, irq_o);
    apb(1, `TEG_OFS_CTRL, 0); apb(1, `TEG_OFS_STATUS, 0);
    compare_i <= 4'hf; tick(1); compare_i <= 0; tick(2);
    ch_data_rd_i <= 4'hf; tick(1); ch_data_rd_i <= 0; tick(2);
    stat("compare flags", 32'h001e);
    apb(1, `TEG_OFS_STATUS, 0);
  endtask

  task t_trig();
    apb(1, `TEG_OFS_REQ_EN, 32'h4040); snap = far.cnt;
    trigger_input_i <= 1; tick(3);
    stat("trg flag", 32'h0040);
    dma(5, 1);
    chk("irq trg", 1, irq_o);
    apb(1, `TEG_OFS_STATUS, 0); trigger_input_i <= 0; tick(3);
    stat("fall ignored", 0);
    apb(1, `TEG_OFS_REQ_EN, 0); apb(1, `TEG_OFS_CTRL, 32'h0050); snap = far.cnt;
    trigger_input_i <= 1; tick(3);
    chk("susp count", 1, count_en_o);
    dma(5, 0);
    chk("irq trg masked", 0, irq_o);
    apb(1, `TEG_OFS_STATUS, 0); trigger_input_i <= 0; tick(3);
    stat("susp fall", 32'h0040);
    chk("susp stop", 0, count_en_o);
    apb(1, `TEG_OFS_CTRL, 32'h0004); apb(1, `TEG_OFS_STATUS, 0);
    trigger_input_i <= 1; tick(3);
    stat("rise ignored", 0);
    trigger_input_i <= 0; tick(3);
    stat("fall active", 32'h0040);
    apb(1, `TEG_OFS_CTRL, 0); apb(1, `TEG_OFS_STATUS, 0);
  endtask

  task t_swovf();
    apb(1, `TEG_OFS_SW_EVENT, 1); tick(1);
    stat("sw ovf", 1);
    apb(1, `TEG_OFS_STATUS, 0); apb(1, `TEG_OFS_CTRL, 1);
    apb(1, `TEG_OFS_SW_EVENT, 1); tick(1);
    stat("sw ovf gated", 0);
    apb(1, `TEG_OFS_CTRL, 32'h0040);
    trigger_input_i <= 1; tick(2);
    chk("reinit pulse", 1, counter_reinit_o);
    tick(1);
    stat("reinit ovf", 32'h0041);
    apb(1, `TEG_OFS_CTRL, 32'h0042); apb(1, `TEG_OFS_STATUS, 0);
    trigger_input_i <= 0; tick(2); trigger_input_i <= 1; tick(3);
    stat("reinit gated", 32'h0040);
  endtask

  // Watchdog
  initial begin
    #(50 * 8000);
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    tick(20);
    srst_i <= 0;
    tick(1);
    t_reset();
    t_ovf();
    t_chan();
    t_trig();
    t_swovf();
    results();
  end
endmodule
